// ==== src/fmt_pkg.sv ====
// constants for the format and paper control block
// Behaviour
// - self test forces one line feed
// - format-mode flag selects format-unit path
// - channel not found posts code 14
// - found channel: move lines to mark
// - format-unit count word gives steps directly
// - compare code to each reference code
// - unknown code posts 25, saves counts, halts
// - line or form feed clears return count
// - skipover landing jumps to next top
// - form feed steps to top of form
// - inhibit master clear before paper moves
// - return count past limit posts 24
// - return within limit counts, releases, idles
// - one line per step, phased, density delay
// - each step: moved count up, line up
// - eight steps without motion means jam
// - steps equal required: release, idle
// - status change starts check, clears faults
// - resample after 200 ns before identifying
// - test each status port fault input
// - fault present stores code, stops printer
// - fault stops hammers, paper, band together
package fmt_pkg;
	localparam int          CLK_MHZ          = 100;
	localparam int          RESAMPLE_NS      = 200;
	localparam int          RESAMPLE_CYC     = (RESAMPLE_NS * CLK_MHZ + 999) / 1000;
	localparam int          PHASE_US_6LPI    = 40;
	localparam int          PHASE_US_8LPI    = 30;
	localparam int          PHASE_CYC_6      = PHASE_US_6LPI * CLK_MHZ;
	localparam int          PHASE_CYC_8      = PHASE_US_8LPI * CLK_MHZ;
	localparam logic [7:0]  CODE_LF          = 8'h0A;
	localparam logic [7:0]  CODE_FF          = 8'h0C;
	localparam logic [7:0]  CODE_CR          = 8'h0D;
	localparam int          CHAN_BIT         = 7;
	localparam int          CHAN_SEL_BIT     = 6;
	localparam logic [7:0]  FAULT_NONE       = 8'h00;
	localparam logic [7:0]  FAULT_CHAN       = 8'h14;
	localparam logic [7:0]  FAULT_CR         = 8'h24;
	localparam logic [7:0]  FAULT_CODE       = 8'h25;
	localparam logic [7:0]  FAULT_JAM        = 8'h30;
	localparam logic [7:0]  FAULT_PORT_BASE  = 8'h01;
	localparam logic [7:0]  CR_LIMIT_LO      = 8'h08;
	localparam logic [7:0]  CR_LIMIT_HI      = 8'h8C;
	localparam logic [3:0]  JAM_LIMIT        = 4'h8;
	localparam logic [7:0]  FORM_LEN_RST     = 8'h42;
	localparam logic [7:0]  LAST_PRINT_RST   = 8'h3C;
	localparam int          LINE_W           = 8;
	localparam int          VFU_AW           = 8;
	localparam int          VFU_DW           = 12;
	localparam int          STATUS_W         = 8;
	localparam int          PHASES           = 4;
endpackage : fmt_pkg

// ==== src/vfu_mem.sv ====
// vertical format unit channel memory, one word per form line
`timescale 1ns/1ps
module vfu_mem (
	input  wire logic                        clk_i,
	input  wire logic                        we_i,
	input  wire logic [fmt_pkg::VFU_AW-1:0]  waddr_i,
	input  wire logic [fmt_pkg::VFU_DW-1:0]  wdata_i,
	input  wire logic [fmt_pkg::VFU_AW-1:0]  raddr_i,
	output logic      [fmt_pkg::VFU_DW-1:0]  rdata_o
);
	import fmt_pkg::*;
	logic [VFU_DW-1:0] mem [0:(1<<VFU_AW)-1];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : vfu_mem

// ==== src/printer_format_paper_control.sv ====
// format decode, paper motion and status check for the line printer
`timescale 1ns/1ps
module printer_format_paper_control (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          start_i,
	input  wire logic [7:0]                    user_data_i,
	input  wire logic                          self_test_i,
	input  wire logic                          vfu_mode_i,
	input  wire logic                          skipover_en_i,
	input  wire logic                          cr_limit_hi_i,
	input  wire logic                          density_8lpi_i,
	input  wire logic                          sprocket_i,
	input  wire logic                          status_change_line_i,
	input  wire logic [fmt_pkg::STATUS_W-1:0]  status_port_i,
	input  wire logic                          vfu_we_i,
	input  wire logic [fmt_pkg::VFU_AW-1:0]    vfu_waddr_i,
	input  wire logic [fmt_pkg::VFU_DW-1:0]    vfu_wdata_i,
	input  wire logic                          reinit_i,
	output logic                               busy_o,
	output logic                               master_clear_inhibit_o,
	output logic      [fmt_pkg::PHASES-1:0]    motor_phase_o,
	output logic                               paper_enable_o,
	output logic                               hammer_enable_o,
	output logic                               band_enable_o,
	output logic                               save_counts_o,
	output logic                               halted_o,
	output logic      [7:0]                    fault_code_o,
	output logic      [fmt_pkg::LINE_W-1:0]    line_o
);
	import fmt_pkg::*;

	typedef enum {
		S_IDLE, S_DECODE, S_SEARCH, S_SEARCH_WAIT, S_PLAN, S_STEP,
		S_UPDATE, S_CHK_CLEAR, S_CHK_WAIT, S_CHK_ID, S_HALT
	} state_t;

	state_t            state_reg;
	state_t            ret_reg;
	logic [7:0]        code_reg;
	logic [LINE_W-1:0] line_reg;
	logic [LINE_W-1:0] steps_reg;
	logic [LINE_W-1:0] moved_reg;
	logic [7:0]        cr_cnt_reg;
	logic [3:0]        jam_cnt_reg;
	logic              motion_flag_reg;
	logic [1:0]        phase_idx_reg;
	logic [2:0]        phase_cnt_reg;
	logic [15:0]       tmr_reg;
	logic [VFU_AW-1:0] srch_reg;
	logic [LINE_W-1:0] srch_n_reg;
	logic [VFU_DW-1:0] vfu_rdata;
	logic [2:0]        sync_sc;
	logic [2:0]        sync_sp;
	logic              sc_reg;
	logic              sp_reg;
	logic              sp_old_reg;
	logic [7:0]        fault_reg;

	// steps from current line to the line after skip, wrapping at form end
	function automatic logic [LINE_W-1:0] dist_to(input logic [LINE_W-1:0] cur,
			input logic [LINE_W-1:0] dst);
		logic [LINE_W-1:0] d;
		d = (dst > cur) ? LINE_W'(dst - cur) : LINE_W'(FORM_LEN_RST - cur + dst);
		return d;
	endfunction : dist_to

	// three-stage sync; a change counts once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_sc <= 3'h0;
			sync_sp <= 3'h0;
			sc_reg  <= 1'b0;
			sp_reg  <= 1'b0;
		end else begin
			sync_sc <= {sync_sc[1:0], status_change_line_i};
			sync_sp <= {sync_sp[1:0], sprocket_i};
			if (sync_sc[1] == sync_sc[2]) begin
				sc_reg <= sync_sc[2];
			end
			if (sync_sp[1] == sync_sp[2]) begin
				sp_reg <= sync_sp[2];
			end
		end
	end

	vfu_mem u_vfu (
		.clk_i   (clk_i),
		.we_i    (vfu_we_i),
		.waddr_i (vfu_waddr_i),
		.wdata_i (vfu_wdata_i),
		.raddr_i (srch_reg),
		.rdata_o (vfu_rdata)
	);

	logic [LINE_W-1:0] next_line;
	logic              is_chan;
	logic [15:0]       phase_len;
	logic [15:0]       chan_word;
	logic              chan_hit;
	assign next_line = (line_reg + 8'h01 >= FORM_LEN_RST) ? 8'h00 : line_reg + 8'h01;
	assign is_chan   = code_reg[CHAN_BIT];
	assign phase_len = density_8lpi_i ? 16'(PHASE_CYC_8) : 16'(PHASE_CYC_6);
	// channels past the word width read as unmarked, not as unknown
	assign chan_word = 16'(vfu_rdata);
	assign chan_hit  = chan_word[code_reg[3:0]];

	// main sequencer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg        <= S_IDLE;
			ret_reg          <= S_IDLE;
			code_reg         <= 8'h00;
			line_reg         <= 8'h00;
			steps_reg        <= 8'h00;
			moved_reg        <= 8'h00;
			cr_cnt_reg       <= 8'h00;
			jam_cnt_reg      <= 4'h0;
			motion_flag_reg  <= 1'b0;
			phase_idx_reg    <= 2'h0;
			phase_cnt_reg    <= 3'h0;
			tmr_reg          <= 16'h0000;
			srch_reg         <= 8'h00;
			srch_n_reg       <= 8'h00;
			sp_old_reg       <= 1'b0;
			fault_reg        <= FAULT_NONE;
			master_clear_inhibit_o <= 1'b0;
			save_counts_o    <= 1'b0;
		end else begin
			save_counts_o <= 1'b0;
			sp_old_reg    <= sp_reg;
			if (sp_reg && !sp_old_reg) begin
				motion_flag_reg <= 1'b1;
			end
			if (sc_reg && state_reg != S_HALT && state_reg != S_CHK_CLEAR
					&& state_reg != S_CHK_WAIT && state_reg != S_CHK_ID) begin
				ret_reg   <= state_reg;
				state_reg <= S_CHK_CLEAR;
			end else begin
				unique case (state_reg)
				S_IDLE: begin
					if (start_i) begin
						code_reg  <= user_data_i;
						state_reg <= S_DECODE;
					end
				end
				S_DECODE: begin
					moved_reg <= 8'h00;
					if (self_test_i) begin
						steps_reg  <= 8'h01;
						cr_cnt_reg <= 8'h00;
						master_clear_inhibit_o <= 1'b1;
						state_reg  <= S_STEP;
					end else if (vfu_mode_i) begin
						if (is_chan) begin
							srch_reg    <= next_line;
							srch_n_reg  <= 8'h01;
							state_reg   <= S_SEARCH;
						end else begin
							steps_reg <= {1'b0, code_reg[6:0]};
							state_reg <= S_PLAN;
						end
					end else if (code_reg == CODE_LF) begin
						steps_reg <= 8'h01;
						state_reg <= S_PLAN;
					end else if (code_reg == CODE_FF) begin
						steps_reg <= dist_to(line_reg, 8'h00);
						cr_cnt_reg <= 8'h00;
						master_clear_inhibit_o <= 1'b1;
						state_reg <= S_STEP;
					end else if (code_reg == CODE_CR) begin
						if (cr_cnt_reg >= (cr_limit_hi_i ? CR_LIMIT_HI : CR_LIMIT_LO)) begin
							fault_reg <= FAULT_CR;
							state_reg <= S_HALT;
						end else begin
							cr_cnt_reg <= cr_cnt_reg + 8'h01;
							master_clear_inhibit_o <= 1'b0;
							state_reg <= S_IDLE;
						end
					end else begin
						fault_reg     <= FAULT_CODE;
						save_counts_o <= 1'b1;
						state_reg     <= S_HALT;
					end
				end
				S_SEARCH: begin
					// memory read takes one cycle, so wait one state
					state_reg   <= S_SEARCH_WAIT;
				end
				S_SEARCH_WAIT: begin
					if (chan_hit) begin
						steps_reg <= srch_n_reg;
						state_reg <= S_PLAN;
					end else if (srch_n_reg >= FORM_LEN_RST) begin
						fault_reg <= FAULT_CHAN;
						state_reg <= S_HALT;
					end else begin
						srch_reg   <= (srch_reg + 8'h01 >= FORM_LEN_RST) ? 8'h00
								: srch_reg + 8'h01;
						srch_n_reg <= srch_n_reg + 8'h01;
						state_reg  <= S_SEARCH;
					end
				end
				S_PLAN: begin
					cr_cnt_reg <= 8'h00;
					if (steps_reg == 8'h00) begin
						state_reg <= S_IDLE;
					end else begin
						if (skipover_en_i && line_reg + steps_reg > LAST_PRINT_RST) begin
							steps_reg <= dist_to(line_reg, 8'h00);
						end
						master_clear_inhibit_o <= 1'b1;
						phase_cnt_reg <= 3'h0;
						tmr_reg       <= 16'h0000;
						state_reg     <= S_STEP;
					end
				end
				S_STEP: begin
					if (tmr_reg + 16'h0001 >= phase_len) begin
						tmr_reg       <= 16'h0000;
						phase_idx_reg <= phase_idx_reg + 2'h1;
						phase_cnt_reg <= phase_cnt_reg + 3'h1;
						if (phase_cnt_reg == 3'(PHASES - 1)) begin
							phase_cnt_reg <= 3'h0;
							state_reg     <= S_UPDATE;
						end
					end else begin
						tmr_reg <= tmr_reg + 16'h0001;
					end
				end
				S_UPDATE: begin
					line_reg  <= next_line;
					moved_reg <= moved_reg + 8'h01;
					if (motion_flag_reg) begin
						jam_cnt_reg     <= 4'h0;
						// an edge in this very cycle outlives the clear
						motion_flag_reg <= sp_reg && !sp_old_reg;
					end else begin
						jam_cnt_reg <= jam_cnt_reg + 4'h1;
					end
					if (!motion_flag_reg && jam_cnt_reg + 4'h1 >= JAM_LIMIT) begin
						fault_reg <= FAULT_JAM;
						state_reg <= S_HALT;
					end else if (moved_reg + 8'h01 == steps_reg) begin
						master_clear_inhibit_o <= 1'b0;
						state_reg <= S_IDLE;
					end else begin
						state_reg <= S_STEP;
					end
				end
				S_CHK_CLEAR: begin
					fault_reg <= FAULT_NONE;
					tmr_reg   <= 16'h0000;
					state_reg <= S_CHK_WAIT;
				end
				S_CHK_WAIT: begin
					if (tmr_reg + 16'h0001 >= 16'(RESAMPLE_CYC)) begin
						tmr_reg   <= 16'h0000;
						state_reg <= sc_reg ? S_CHK_ID : ret_reg;
					end else begin
						tmr_reg <= tmr_reg + 16'h0001;
					end
				end
				S_CHK_ID: begin
					state_reg <= ret_reg;
					for (int i = STATUS_W - 1; i >= 0; i--) begin
						if (status_port_i[i]) begin
							fault_reg <= FAULT_PORT_BASE + 8'(i);
							state_reg <= S_HALT;
						end
					end
				end
				S_HALT: begin
					master_clear_inhibit_o <= 1'b0;
					if (reinit_i) begin
						fault_reg   <= FAULT_NONE;
						cr_cnt_reg  <= 8'h00;
						jam_cnt_reg <= 4'h0;
						state_reg   <= S_IDLE;
					end
				end
				endcase
			end
		end
	end

	logic running;
	assign running = (state_reg != S_HALT);
	assign hammer_enable_o = running;
	assign band_enable_o   = running;
	assign paper_enable_o  = running && state_reg == S_STEP;
	assign halted_o        = !running;
	assign busy_o          = state_reg != S_IDLE;
	assign fault_code_o    = fault_reg;
	assign line_o          = line_reg;
	assign motor_phase_o   = paper_enable_o ? (4'h1 << phase_idx_reg) : 4'h0;

	a_halt_stops_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		halted_o |-> !hammer_enable_o && !band_enable_o && !paper_enable_o)
		else $error("fault did not stop printer");
	a_unknown_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		save_counts_o |-> fault_code_o == FAULT_CODE && halted_o)
		else $error("unknown code not faulted");
	a_inhibit_moving: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		paper_enable_o |-> master_clear_inhibit_o)
		else $error("paper moves without inhibit");
	a_jam_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		jam_cnt_reg <= JAM_LIMIT)
		else $error("jam count past limit");
	a_line_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_UPDATE && !sc_reg |=> line_o == $past(next_line))
		else $error("line not advanced");
	a_fault_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		halted_o && !reinit_i |=> halted_o && $stable(fault_code_o))
		else $error("fault code not held");
	a_check_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_CHK_CLEAR |=> fault_code_o == FAULT_NONE)
		else $error("faults not cleared on check");
	a_resample_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_CHK_CLEAR |=> state_reg == S_CHK_WAIT [*2])
		else $error("resample wait too short");
	a_cr_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cr_cnt_reg <= CR_LIMIT_HI)
		else $error("return count past limit");
	a_self_test_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_DECODE && self_test_i && !sc_reg
		|=> state_reg == S_STEP && steps_reg == 8'h01)
		else $error("self test did not take one line");
	a_chan_missing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_SEARCH_WAIT && !sc_reg && !chan_hit && srch_n_reg >= FORM_LEN_RST
		|=> halted_o && fault_code_o == FAULT_CHAN)
		else $error("missing channel not faulted");
	a_cr_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_DECODE && !sc_reg && !self_test_i && !vfu_mode_i
		&& code_reg == CODE_CR && cr_cnt_reg < (cr_limit_hi_i ? CR_LIMIT_HI : CR_LIMIT_LO)
		|=> !busy_o && !master_clear_inhibit_o && $stable(line_o))
		else $error("return not finished in place");
	a_dest_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_UPDATE && !sc_reg && motion_flag_reg && moved_reg + 8'h01 == steps_reg
		|=> !busy_o && !master_clear_inhibit_o)
		else $error("move did not end at destination");
	a_phase_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		paper_enable_o |-> $onehot(motor_phase_o))
		else $error("motor phase not one-hot");
	a_status_resume: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		state_reg == S_CHK_WAIT && !sc_reg && tmr_reg + 16'h0001 >= 16'(RESAMPLE_CYC)
		|=> state_reg == ret_reg)
		else $error("glitch did not resume");
	c_jam: cover property (@(posedge clk_i) fault_code_o == FAULT_JAM);
	c_cr_fault: cover property (@(posedge clk_i) fault_code_o == FAULT_CR);
	c_move_done: cover property (@(posedge clk_i) state_reg == S_UPDATE ##1 state_reg == S_IDLE);
	c_status_fault: cover property (@(posedge clk_i) state_reg == S_CHK_ID ##1 halted_o);
endmodule : printer_format_paper_control

// ==== verification/paper_feed_model.sv ====
// paper feed motor and sprocket sensor model facing the block
`timescale 1ns/1ps
module paper_feed_model (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic [fmt_pkg::PHASES-1:0]  motor_phase_i,
	input  wire logic                        paper_enable_i,
	output logic                             sprocket_o
);
	logic [fmt_pkg::PHASES-1:0] phase_reg;
	logic [1:0]                 hold_reg;
	// one hole per full phase turn; the sensor line is pulled low otherwise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= '0;
			hold_reg  <= 2'h0;
		end else begin
			phase_reg <= motor_phase_i;
			if (paper_enable_i && motor_phase_i[fmt_pkg::PHASES-1] &&
					!phase_reg[fmt_pkg::PHASES-1]) begin
				hold_reg <= 2'h3;
			end else if (hold_reg != 2'h0) begin
				hold_reg <= hold_reg - 2'h1;
			end
		end
	end
	assign sprocket_o = (hold_reg != 2'h0);
endmodule : paper_feed_model

// ==== verification/printer_format_paper_control_tb.sv ====
// self-checking bench for the format and paper control block
`timescale 1ns/1ps
module printer_format_paper_control_tb;
	import fmt_pkg::*;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              start, self_test, vfu_mode, sprocket, stat_line, vfu_we, reinit, cr_hi;
	logic [7:0]        user_data, status_port, vfu_waddr, fault, line, pv;
	logic [VFU_DW-1:0] vfu_wdata;
	logic              busy, mci, paper_en, hammer_en, band_en, save_cnt, halted, saw_save;
	logic [PHASES-1:0] phase;
	int                n_fail = 0;
	int                num_checks = 0;
	int                cycles = 0;
	int                i;

	always #5 clk = ~clk;

	printer_format_paper_control dut (.clk_i(clk), .rst_n_i(rst_n), .start_i(start),
		.user_data_i(user_data), .self_test_i(self_test), .vfu_mode_i(vfu_mode),
		.skipover_en_i(1'b0), .cr_limit_hi_i(cr_hi), .density_8lpi_i(1'b1),
		.sprocket_i(sprocket), .status_change_line_i(stat_line), .status_port_i(status_port),
		.vfu_we_i(vfu_we), .vfu_waddr_i(vfu_waddr), .vfu_wdata_i(vfu_wdata), .reinit_i(reinit),
		.busy_o(busy), .master_clear_inhibit_o(mci), .motor_phase_o(phase),
		.paper_enable_o(paper_en), .hammer_enable_o(hammer_en), .band_enable_o(band_en),
		.save_counts_o(save_cnt), .halted_o(halted), .fault_code_o(fault), .line_o(line));

	paper_feed_model feed (.clk_i(clk), .rst_n_i(rst_n), .motor_phase_i(phase),
		.paper_enable_i(paper_en), .sprocket_o(sprocket));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// four 8 lpi lines at about 12000 cycles each plus short tests
	always @(posedge clk) begin
		cycles++;
		if (cycles == 70000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	function automatic logic [7:0] rand_bad();
		logic [7:0] r;
		r = 8'($urandom) & 8'h7F;
		while (r == CODE_LF || r == CODE_FF || r == CODE_CR) r = r + 8'h01;
		return r;
	endfunction : rand_bad

	function automatic logic [7:0] port_code(input logic [7:0] p);
		for (int b = 0; b < 8; b++) if (p[b]) return FAULT_PORT_BASE + 8'(b);
		return FAULT_NONE;
	endfunction : port_code

	task automatic go(input logic [7:0] c);
		@(posedge clk);
		start <= 1'b1;
		user_data <= c;
		@(posedge clk);
		start <= 1'b0;
	endtask : go

	// halt counts as done: a fault state never returns to idle by itself
	task automatic wait_done();
		saw_save = 1'b0;
		for (int k = 0; k < 20000; k++) begin
			@(posedge clk);
			#1;
			if (save_cnt === 1'b1) saw_save = 1'b1;
			if (busy !== 1'b1 || halted === 1'b1) break;
		end
	endtask : wait_done

	task automatic chk_halt(input logic [7:0] exp);
		chk(fault, exp, "fault code");
		chk(8'({halted, hammer_en, band_en, paper_en}), 8'h08, "shutdown outputs");
	endtask : chk_halt

	task automatic do_reinit();
		@(posedge clk);
		reinit <= 1'b1;
		repeat (3) @(posedge clk);
		reinit <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(8'(halted), 8'h00, "halt left after reinit");
	endtask : do_reinit

	initial begin
		start = 1'b0; self_test = 1'b0; vfu_mode = 1'b0; stat_line = 1'b0; vfu_we = 1'b0;
		reinit = 1'b0; user_data = 8'h00; status_port = 8'h00; vfu_waddr = 8'h00;
		vfu_wdata = '0;
		cr_hi = 1'b0;
		i = $urandom(94);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// empty channel memory so no channel mark exists anywhere
		for (i = 0; i < 256; i++) begin
			@(posedge clk);
			vfu_we <= 1'b1;
			vfu_waddr <= 8'(i);
		end
		@(posedge clk);
		vfu_we <= 1'b0;
		for (i = 0; i < 5; i++) begin
			go(CODE_CR);
			wait_done();
		end
		chk(line, 8'h00, "no paper motion on return");
		chk(8'(mci), 8'h00, "inhibit released after return");
		$display("test returns done");
		go(CODE_LF);
		repeat (100) @(posedge clk);
		#1;
		chk(8'({mci, paper_en}), 8'h03, "inhibit while moving");
		chk(8'($onehot(phase)), 8'h01, "one motor phase");
		wait_done();
		chk(line, 8'h01, "line after feed");
		chk(8'(mci), 8'h00, "inhibit released at destination");
		$display("test line feed done");
		self_test <= 1'b1;
		go(rand_bad());
		wait_done();
		self_test <= 1'b0;
		chk(line, 8'h02, "self test line");
		chk(fault, FAULT_NONE, "self test no fault");
		vfu_mode <= 1'b1;
		go(8'h01);
		wait_done();
		vfu_mode <= 1'b0;
		chk(line, 8'h03, "format count line");
		$display("test self test and count done");
		// both switch settings of the return limit
		for (int h = 0; h < 2; h++) begin
			cr_hi <= 1'(h);
			for (i = 0; i < (h != 0 ? CR_LIMIT_HI : CR_LIMIT_LO); i++) begin
				go(CODE_CR);
				wait_done();
			end
			chk(fault, FAULT_NONE, "returns up to limit");
			go(CODE_CR);
			wait_done();
			chk_halt(FAULT_CR);
			chk(line, 8'h03, "faulted return keeps line");
			do_reinit();
		end
		$display("test return limit done");
		for (int n = 0; n < 3; n++) begin
			go(rand_bad());
			wait_done();
			chk(8'(saw_save), 8'h01, "counts saved");
			chk_halt(FAULT_CODE);
			do_reinit();
		end
		$display("test unknown codes done");
		vfu_mode <= 1'b1;
		go(8'h80 | (8'($urandom) & 8'h0F));
		wait_done();
		vfu_mode <= 1'b0;
		chk_halt(FAULT_CHAN);
		do_reinit();
		$display("test channel not found done");
		pv = 8'($urandom % VFU_DW);
		@(posedge clk);
		vfu_we <= 1'b1;
		vfu_waddr <= line + 8'h01;
		vfu_wdata <= VFU_DW'(1) << pv;
		@(posedge clk);
		vfu_we <= 1'b0;
		vfu_mode <= 1'b1;
		go(8'h80 | pv);
		wait_done();
		vfu_mode <= 1'b0;
		chk(line, 8'h04, "line at channel mark");
		chk(fault, FAULT_NONE, "channel mark found");
		$display("test channel found done");
		// port faults already present, so a missed resample would halt
		pv = 8'($urandom) | 8'h80;
		@(posedge clk);
		status_port <= pv;
		stat_line <= 1'b1;
		repeat (2) @(posedge clk);
		stat_line <= 1'b0;
		repeat (60) @(posedge clk);
		#1;
		chk(fault, FAULT_NONE, "glitch ignored");
		chk(8'({halted, hammer_en, band_en}), 8'h03, "glitch left printer running");
		@(posedge clk);
		stat_line <= 1'b1;
		repeat (60) @(posedge clk);
		#1;
		chk_halt(port_code(pv));
		$display("test status check done");
		end_sim();
	end
endmodule : printer_format_paper_control_tb
